// ---- logic/aror_pkg.sv ----
// register map, field layout and reset values of the alert/reset/oscillator slice
// assumes an 8-bit register access port driven by the serial target front end
package aror_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] LOW_FLAGS_ADDR = 8'h0C;
  localparam logic [7:0] HIGH_FLAGS_ADDR = 8'h0E;
  localparam logic [7:0] SOFT_RESET_ADDR = 8'h14;
  localparam logic [7:0] CAL_START_ADDR = 8'h15;
  localparam logic [7:0] UNLOCK_KEY_ADDR = 8'h17;
  localparam logic [7:0] OSC_CHOICE_ADDR = 8'h18;
  localparam logic [7:0] CONV_COUNT_ADDR = 8'h19;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int CH_COUNT = 2;
  localparam int GO_BIT_POS = 0;
  localparam int OSC_BIT_POS = 0;
  localparam int KEY_WIDTH = 4;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] UNLOCK_CODE = 4'hA;
  localparam logic [3:0] KEY_RESET = 4'h0;
  localparam logic [1:0] FLAGS_RESET = 2'h0;
  localparam logic OSC_RESET = 1'b0;
  localparam logic [7:0] CONV_COUNT_RESET = 8'h00;
  localparam logic [7:0] FAST_OSC_MIN_CLKS = 8'h15;
  localparam logic [7:0] SLOW_OSC_MIN_CLKS = 8'h12;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // register access request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aror_req_t;

endpackage

// ---- logic/aror_flag_bank.sv ----
// sticky event flag bank: hardware sets, register write of zero clears
// assumes set inputs synchronous to the core clock
`timescale 1ns/10ps
module aror_flag_bank #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic clear_all_i,
  input wire logic wr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [WIDTH-1:0] set_i,
  output logic [WIDTH-1:0] flags_o
);

  // ----------------------------------------------------------------
  // flag storage
  // ----------------------------------------------------------------
  // set beats any clear in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_o <= '0;
    end else if (clk_en_i) begin
      if (clear_all_i) begin
        flags_o <= set_i;
      end else if (wr_i) begin
        flags_o <= (flags_o & wdata_i) | set_i; // writing zero clears
      end else begin
        flags_o <= flags_o | set_i;
      end
    end
  end

endmodule

// ---- logic/aror_regs.sv ----
// alert flag, keyed soft reset, calibration trigger and oscillator registers
// assumes the serial target front end presents one access per cycle at most
//
// Behaviour
// - Low-side alert flags for channel 0 and 1 sit in bits 0 and 1 at 0x0C.
// - High-side alert flags for channel 0 and 1 sit in bits 0 and 1 at 0x0E.
// - Writing one to bit 0 at 0x14 resets the device, all but the unlock key, when unlocked.
// - Writes to 0x14 are taken only after key 1010b sits in the low nibble at 0x17.
// - The unlock key survives a device reset.
// - Writing one to bit 0 at 0x15 starts offset calibration.
// - Bit 0 at 0x18 picks the fast oscillator at zero and the low-power one at one.
// - Reserved upper bits of flag, reset, calibration and oscillator registers read zero.
// - Flag registers and the conversion clock count at 0x19 reset to zero.
// - A written conversion clock count is raised to 21 (fast) or 18 (low-power) at least, per the oscillator selected at the write.
`timescale 1ns/10ps
module aror_regs (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CLK_EN_I,
  input wire aror_pkg::aror_req_t REG_REQ_I,
  input wire logic [1:0] LOW_ALERT_SET_I,
  input wire logic [1:0] HIGH_ALERT_SET_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  output logic SOFT_RESET_O,
  output logic CAL_START_O,
  output logic LOW_POWER_OSC_O,
  output logic [7:0] CYCLES_PER_CONV_O,
  output logic [1:0] LOW_FLAGS_O,
  output logic [1:0] HIGH_FLAGS_O
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr_low, wr_high, wr_rst, wr_cal, wr_key, wr_osc, wr_cnt;
  logic unlocked;
  logic [3:0] key_r;
  logic [7:0] cnt_floor;

  assign wr_low = REG_REQ_I.wr && (REG_REQ_I.addr == aror_pkg::LOW_FLAGS_ADDR);
  assign wr_high = REG_REQ_I.wr && (REG_REQ_I.addr == aror_pkg::HIGH_FLAGS_ADDR);
  assign wr_rst = REG_REQ_I.wr && (REG_REQ_I.addr == aror_pkg::SOFT_RESET_ADDR);
  assign wr_cal = REG_REQ_I.wr && (REG_REQ_I.addr == aror_pkg::CAL_START_ADDR);
  assign wr_key = REG_REQ_I.wr && (REG_REQ_I.addr == aror_pkg::UNLOCK_KEY_ADDR);
  assign wr_osc = REG_REQ_I.wr && (REG_REQ_I.addr == aror_pkg::OSC_CHOICE_ADDR);
  assign wr_cnt = REG_REQ_I.wr && (REG_REQ_I.addr == aror_pkg::CONV_COUNT_ADDR);
  assign unlocked = (key_r == aror_pkg::UNLOCK_CODE);
  // floor follows the oscillator selected when the count is written
  assign cnt_floor = LOW_POWER_OSC_O ? aror_pkg::SLOW_OSC_MIN_CLKS
                                     : aror_pkg::FAST_OSC_MIN_CLKS;

  // ----------------------------------------------------------------
  // alert flags
  // ----------------------------------------------------------------
  // low-side flags, cleared as a whole by soft reset
  aror_flag_bank #(.WIDTH(aror_pkg::CH_COUNT)) u_low_flags (
    .clk_i(CORE_CLK_I),
    .reset_n_i(RESET_N_I),
    .clk_en_i(CLK_EN_I),
    .clear_all_i(SOFT_RESET_O),
    .wr_i(wr_low),
    .wdata_i(REG_REQ_I.wdata[1:0]),
    .set_i(LOW_ALERT_SET_I),
    .flags_o(LOW_FLAGS_O)
  );

  // high-side flags
  aror_flag_bank #(.WIDTH(aror_pkg::CH_COUNT)) u_high_flags (
    .clk_i(CORE_CLK_I),
    .reset_n_i(RESET_N_I),
    .clk_en_i(CLK_EN_I),
    .clear_all_i(SOFT_RESET_O),
    .wr_i(wr_high),
    .wdata_i(REG_REQ_I.wdata[1:0]),
    .set_i(HIGH_ALERT_SET_I),
    .flags_o(HIGH_FLAGS_O)
  );

  // ----------------------------------------------------------------
  // unlock key
  // ----------------------------------------------------------------
  // soft reset deliberately leaves the key alone
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      key_r <= aror_pkg::KEY_RESET;
    end else if (CLK_EN_I && wr_key) begin
      key_r <= REG_REQ_I.wdata[3:0]; // upper nibble dropped
    end
  end

  // ----------------------------------------------------------------
  // soft reset and calibration strobes
  // ----------------------------------------------------------------
  // one-cycle pulses; a locked reset write is ignored
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SOFT_RESET_O <= 1'b0;
      CAL_START_O <= 1'b0;
    end else if (CLK_EN_I) begin
      SOFT_RESET_O <= wr_rst && REG_REQ_I.wdata[aror_pkg::GO_BIT_POS] && unlocked;
      CAL_START_O <= wr_cal && REG_REQ_I.wdata[aror_pkg::GO_BIT_POS] && !SOFT_RESET_O;
    end
  end

  // ----------------------------------------------------------------
  // oscillator choice and conversion clock count
  // ----------------------------------------------------------------
  // oscillator select bit
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      LOW_POWER_OSC_O <= aror_pkg::OSC_RESET;
    end else if (CLK_EN_I) begin
      if (SOFT_RESET_O) begin
        LOW_POWER_OSC_O <= aror_pkg::OSC_RESET;
      end else if (wr_osc) begin
        LOW_POWER_OSC_O <= REG_REQ_I.wdata[aror_pkg::OSC_BIT_POS];
      end
    end
  end

  // clock count, raised to the oscillator floor on write
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CYCLES_PER_CONV_O <= aror_pkg::CONV_COUNT_RESET;
    end else if (CLK_EN_I) begin
      if (SOFT_RESET_O) begin
        CYCLES_PER_CONV_O <= aror_pkg::CONV_COUNT_RESET;
      end else if (wr_cnt) begin
        CYCLES_PER_CONV_O <= (REG_REQ_I.wdata > cnt_floor) ? REG_REQ_I.wdata
                                                            : cnt_floor;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read data valid one cycle after the request; unmapped reads zero
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= aror_pkg::READ_ZERO;
      REG_RVALID_O <= 1'b0;
    end else if (CLK_EN_I) begin
      REG_RVALID_O <= REG_REQ_I.rd;
      if (REG_REQ_I.rd) begin
        unique case (REG_REQ_I.addr)
          aror_pkg::LOW_FLAGS_ADDR: REG_RDATA_O <= {6'h00, LOW_FLAGS_O};
          aror_pkg::HIGH_FLAGS_ADDR: REG_RDATA_O <= {6'h00, HIGH_FLAGS_O};
          aror_pkg::UNLOCK_KEY_ADDR: REG_RDATA_O <= {4'h0, key_r};
          aror_pkg::OSC_CHOICE_ADDR: REG_RDATA_O <= {7'h00, LOW_POWER_OSC_O};
          aror_pkg::CONV_COUNT_ADDR: REG_RDATA_O <= CYCLES_PER_CONV_O;
          default: REG_RDATA_O <= aror_pkg::READ_ZERO; // strobes read zero
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [7:0] rd_addr_r;

  // address of the last accepted read
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_addr_r <= 8'h00;
    end else if (CLK_EN_I && REG_REQ_I.rd) begin
      rd_addr_r <= REG_REQ_I.addr;
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_low_flag_set: assert property (CLK_EN_I && LOW_ALERT_SET_I[0] |=> LOW_FLAGS_O[0])
    else $error("low alert ch0 not flagged");
  a_high_flag_set: assert property (CLK_EN_I && HIGH_ALERT_SET_I[1] |=> HIGH_FLAGS_O[1])
    else $error("high alert ch1 not flagged");
  a_flag_sticky: assert property (
    LOW_FLAGS_O[1] && !wr_low && !SOFT_RESET_O |=> LOW_FLAGS_O[1])
    else $error("low alert ch1 dropped without a write");
  a_reset_unlocked: assert property (
    CLK_EN_I && wr_rst && REG_REQ_I.wdata[0] && key_r == aror_pkg::UNLOCK_CODE
    |=> SOFT_RESET_O)
    else $error("unlocked reset write gave no reset");
  a_reset_locked: assert property (
    CLK_EN_I && wr_rst && key_r != aror_pkg::UNLOCK_CODE |=> !SOFT_RESET_O)
    else $error("locked reset write took effect");
  a_key_kept: assert property (
    SOFT_RESET_O && CLK_EN_I && !wr_key |=> key_r == $past(key_r))
    else $error("key lost on soft reset");
  a_soft_clear: assert property (
    SOFT_RESET_O && CLK_EN_I && LOW_ALERT_SET_I == 2'h0 && HIGH_ALERT_SET_I == 2'h0
    |=> LOW_FLAGS_O == 2'h0 && HIGH_FLAGS_O == 2'h0
    && CYCLES_PER_CONV_O == aror_pkg::CONV_COUNT_RESET
    && LOW_POWER_OSC_O == aror_pkg::OSC_RESET)
    else $error("soft reset left state behind");
  a_cal_pulse: assert property (
    CLK_EN_I && wr_cal && REG_REQ_I.wdata[0] && !SOFT_RESET_O
    |=> CAL_START_O ##1 (!CAL_START_O || !$past(CLK_EN_I) || $past(wr_cal)))
    else $error("calibration start not a pulse");
  a_osc_write: assert property (
    CLK_EN_I && wr_osc && !SOFT_RESET_O |=> LOW_POWER_OSC_O == $past(REG_REQ_I.wdata[0]))
    else $error("oscillator choice not stored");
  a_count_floor: assert property (
    CLK_EN_I && wr_cnt && !SOFT_RESET_O
    |=> CYCLES_PER_CONV_O >= ($past(LOW_POWER_OSC_O) ? aror_pkg::SLOW_OSC_MIN_CLKS
                                                     : aror_pkg::FAST_OSC_MIN_CLKS))
    else $error("clock count below oscillator floor");
  a_reserved_zero: assert property (
    REG_RVALID_O && (rd_addr_r == aror_pkg::LOW_FLAGS_ADDR
    || rd_addr_r == aror_pkg::HIGH_FLAGS_ADDR || rd_addr_r == aror_pkg::OSC_CHOICE_ADDR)
    |-> REG_RDATA_O[7:2] == 6'h00)
    else $error("reserved bits read non-zero");
  // strobe registers hold nothing readable
  a_strobe_read_zero: assert property (
    REG_RVALID_O && (rd_addr_r == aror_pkg::SOFT_RESET_ADDR
    || rd_addr_r == aror_pkg::CAL_START_ADDR) |-> REG_RDATA_O == aror_pkg::READ_ZERO)
    else $error("strobe register read non-zero");
  a_key_upper_zero: assert property (
    REG_RVALID_O && rd_addr_r == aror_pkg::UNLOCK_KEY_ADDR |-> REG_RDATA_O[7:4] == 4'h0)
    else $error("key upper nibble read non-zero");

  // host accesses are spaced by an idle cycle, so allow a short gap
  c_soft_reset: cover property (wr_key ##[1:4] wr_rst ##1 SOFT_RESET_O);
  c_locked_try: cover property (wr_rst && REG_REQ_I.wdata[0] && !unlocked);
  c_flag_clear: cover property (LOW_FLAGS_O[0] ##1 wr_low ##1 !LOW_FLAGS_O[0]);
  c_count_raise: cover property (wr_cnt && REG_REQ_I.wdata < aror_pkg::SLOW_OSC_MIN_CLKS);

endmodule

// ---- tb/aror_host_model.sv ----
// host side model: issues register accesses on the parallel target port
// assumes the core clock of the register slice and one access per call
`timescale 1ns/10ps
module aror_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output aror_pkg::aror_req_t req_o
);
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  initial begin
    req_o = '{1'b0, 1'b0, 8'h00, 8'h00};
  end

  // one write, held across one rising edge, then address/data scrambled
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{1'b1, 1'b0, a, d};
    @(negedge clk_i);
    req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask

  // one read, data taken in the cycle the valid pulse stands
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req_o = '{1'b0, 1'b1, a, 8'h5A};
    @(negedge clk_i);
    req_o = '{1'b0, 1'b0, ~a, 8'hA5};
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX; // missing valid pulse shows as unknown
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the alert/reset/oscillator register slice
// assumes the host model drives every register access at falling edges
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [1:0] low_set = 2'h0;
  logic [1:0] high_set = 2'h0;
  aror_pkg::aror_req_t req;
  logic [7:0] rdata, cycles, rd;
  logic rvalid, soft_rst, cal_go, lp_osc;
  logic [1:0] low_flags, high_flags;
  logic [7:0] addrs [8] = '{8'h0C, 8'h0E, 8'h14, 8'h15, 8'h17, 8'h18, 8'h19, 8'h00};
  int err_total = 0;
  int check_count = 0;

  // ----------------------------------------------------------------
  // clock, host and device
  // ----------------------------------------------------------------
  always #5 clk = ~clk;

  aror_host_model i_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

  aror_regs i_dut (
    .CORE_CLK_I(clk), .RESET_N_I(reset_n), .CLK_EN_I(clk_en), .REG_REQ_I(req),
    .LOW_ALERT_SET_I(low_set), .HIGH_ALERT_SET_I(high_set), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .SOFT_RESET_O(soft_rst), .CAL_START_O(cal_go),
    .LOW_POWER_OSC_O(lp_osc), .CYCLES_PER_CONV_O(cycles), .LOW_FLAGS_O(low_flags),
    .HIGH_FLAGS_O(high_flags)
  );

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd_reg(a, rd);
    chk("read data", rd, exp);
  endtask

  task automatic pulse_alerts(input logic [1:0] lo, input logic [1:0] hi);
    @(negedge clk);
    low_set = lo;
    high_set = hi;
    @(negedge clk);
    low_set = 2'h0;
    high_set = 2'h0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    #100000;
    err_total++;
    test_done();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_chk(addrs[i], 8'h00);
    end
    $display("test reset_values done");
    // sticky flags, write one keeps, write zero clears
    pulse_alerts(2'h1, 2'h2);
    chk("low flags", {6'h00, low_flags}, 8'h01);
    chk("high flags", {6'h00, high_flags}, 8'h02);
    rd_chk(8'h0C, 8'h01);
    rd_chk(8'h0E, 8'h02);
    i_host.wr_reg(8'h0E, 8'hFF);
    rd_chk(8'h0E, 8'h02);
    i_host.wr_reg(8'h0C, 8'hFE);
    rd_chk(8'h0C, 8'h00);
    $display("test alert_flags done");
    // oscillator choice and clock count floor
    i_host.wr_reg(8'h19, 8'h05);
    chk("clock count", cycles, 8'h15);
    i_host.wr_reg(8'h19, 8'h16);
    chk("clock count", cycles, 8'h16);
    i_host.wr_reg(8'h18, 8'hFF);
    chk("osc select", {7'h00, lp_osc}, 8'h01);
    rd_chk(8'h18, 8'h01);
    i_host.wr_reg(8'h19, 8'h03);
    rd_chk(8'h19, 8'h12);
    i_host.wr_reg(8'h19, 8'h13);
    rd_chk(8'h19, 8'h13);
    // clock enable low: a write must not land
    @(negedge clk);
    clk_en = 1'b0;
    i_host.wr_reg(8'h19, 8'h40);
    chk("clock count", cycles, 8'h13);
    clk_en = 1'b1;
    rd_chk(8'h19, 8'h13);
    $display("test oscillator done");
    // calibration trigger pulse
    i_host.wr_reg(8'h15, 8'h01);
    chk("cal start", {7'h00, cal_go}, 8'h01);
    @(negedge clk);
    chk("cal start", {7'h00, cal_go}, 8'h00);
    rd_chk(8'h15, 8'h00);
    $display("test calibration done");
    // locked reset register
    i_host.wr_reg(8'h14, 8'h01);
    chk("soft reset", {7'h00, soft_rst}, 8'h00);
    i_host.wr_reg(8'h17, 8'h05);
    i_host.wr_reg(8'h14, 8'h01);
    chk("soft reset", {7'h00, soft_rst}, 8'h00);
    rd_chk(8'h17, 8'h05);
    $display("test locked_reset done");
    // unlocked reset clears state but keeps the key
    pulse_alerts(2'h3, 2'h3);
    i_host.wr_reg(8'h17, 8'h0A);
    i_host.wr_reg(8'h14, 8'h01);
    chk("soft reset", {7'h00, soft_rst}, 8'h01);
    @(negedge clk);
    chk("soft reset", {7'h00, soft_rst}, 8'h00);
    chk("low flags", {6'h00, low_flags}, 8'h00);
    chk("high flags", {6'h00, high_flags}, 8'h00);
    chk("clock count", cycles, 8'h00);
    chk("osc select", {7'h00, lp_osc}, 8'h00);
    rd_chk(8'h17, 8'h0A);
    i_host.wr_reg(8'h17, 8'h00);
    i_host.wr_reg(8'h14, 8'h01);
    chk("soft reset", {7'h00, soft_rst}, 8'h00);
    $display("test unlocked_reset done");
    test_done();
  end
endmodule
